// >>> hdl/ndm_pkg.sv
// package: constants for the nibble dram module controller
package ndm_pkg;
	localparam int unsigned NDM_CLK_MHZ = 40;
	localparam int unsigned NDM_CLK_NS = 25;
	// times in their own units
	localparam int unsigned NDM_INIT_PAUSE_US = 100;
	localparam int unsigned NDM_REF_PERIOD_MS = 8;
	localparam int unsigned NDM_RAS_MIN_NS = 80;
	localparam int unsigned NDM_RP_NS = 70;
	localparam int unsigned NDM_RCD_NS = 25;
	localparam int unsigned NDM_CAS_NS = 20;
	localparam int unsigned NDM_NP_NS = 10;
	localparam int unsigned NDM_CSR_NS = 10;
	localparam int unsigned NDM_RASP_MAX_NS = 100000;
	// derived cycle counts, least times rounded up, longest rounded down
	localparam int unsigned NDM_INIT_CYC = NDM_INIT_PAUSE_US * NDM_CLK_MHZ;
	localparam int unsigned NDM_REF_CYC = NDM_REF_PERIOD_MS * 1000 * NDM_CLK_MHZ;
	localparam int unsigned NDM_RAS_CYC = (NDM_RAS_MIN_NS + NDM_CLK_NS - 1) / NDM_CLK_NS;
	localparam int unsigned NDM_RP_CYC = (NDM_RP_NS + NDM_CLK_NS - 1) / NDM_CLK_NS;
	localparam int unsigned NDM_RCD_CYC = (NDM_RCD_NS + NDM_CLK_NS - 1) / NDM_CLK_NS;
	localparam int unsigned NDM_CAS_CYC = (NDM_CAS_NS + NDM_CLK_NS - 1) / NDM_CLK_NS;
	localparam int unsigned NDM_NP_CYC = (NDM_NP_NS + NDM_CLK_NS - 1) / NDM_CLK_NS;
	localparam int unsigned NDM_CSR_CYC = (NDM_CSR_NS + NDM_CLK_NS - 1) / NDM_CLK_NS;
	localparam int unsigned NDM_RASP_CYC = NDM_RASP_MAX_NS / NDM_CLK_NS;
	// array organisation
	localparam int unsigned NDM_ADDR_W = 10;
	localparam int unsigned NDM_WORD_AW = 20;
	localparam int unsigned NDM_BYTE_W = 8;
	localparam int unsigned NDM_NIB_MAX = 4;
	localparam int unsigned NDM_INIT_RAS = 8;
	localparam int unsigned NDM_REF_ROWS = 512;
	localparam int unsigned NDM_ROW_POS = 10;
	// sequencer states, codes gray in the listed order but not along every transition
	typedef enum logic [3:0] {
		NDM_S_PAUSE = 4'h0,
		NDM_S_WAKE = 4'h1,
		NDM_S_IDLE = 4'h3,
		NDM_S_ROW = 4'h2,
		NDM_S_CLO = 4'h6,
		NDM_S_CHI = 4'h7,
		NDM_S_RUP = 4'h5,
		NDM_S_PRE = 4'h4,
		NDM_S_CBR = 4'hc,
		NDM_S_CBRR = 4'hd
	} ndm_state_t;
endpackage : ndm_pkg

// >>> hdl/ndm_timer.sv
// file: down counter used for every strobe wait; the pause and refresh interval run on the refresh counter
`timescale 1ns/1ps
module ndm_timer #(
	parameter int unsigned W = 24
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [W-1:0] i_count,
	output logic o_done
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	assign cnt_d = i_load ? i_count :
		(cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
	assign o_done = (cnt_q == '0);
	always_ff @(posedge i_mclk) begin
		if (i_rst) cnt_q <= '0;
		else cnt_q <= cnt_d;
	end
endmodule : ndm_timer

// >>> hdl/ndm_ctrl.sv
// file: controller that drives the nibble dram module pins
`timescale 1ns/1ps
// Operation
// - after power-up wait the pause, then eight row strobes before access
// - first bit from external address; more bits by toggling column strobe
// - refresh all 512 rows of the low nine bits in each period
// - refresh by column-before-row cycles issued from a timer
module ndm_ctrl
	import ndm_pkg::*;
#(
	parameter int unsigned INIT_CYC = NDM_INIT_CYC,
	parameter int unsigned REF_CYC = NDM_REF_CYC,
	parameter int unsigned RASP_CYC = NDM_RASP_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [NDM_WORD_AW-1:0] i_addr,
	input wire logic [2:0] i_len_m1,
	input wire logic [NDM_BYTE_W:0] i_wdata,
	output logic o_ready,
	output logic o_init_done,
	output logic o_wdata_take,
	output logic o_rvalid,
	output logic [NDM_BYTE_W:0] o_rdata,
	output logic [1:0] o_nib_idx,
	output logic o_ras_n,
	output logic o_cas_n,
	output logic o_parity_lane_column_strobe_n,
	output logic o_we_n,
	output logic [NDM_ADDR_W-1:0] o_addr,
	output logic [NDM_BYTE_W-1:0] o_shared_byte_lines_out,
	output logic o_shared_byte_lines_oe,
	input wire logic [NDM_BYTE_W-1:0] i_shared_byte_lines,
	output logic o_parity_din,
	input wire logic i_parity_dout
);
	localparam int unsigned TW = 24;
	ndm_state_t st_q, st_d;
	logic [3:0] ras_cnt_q;
	logic [1:0] left_q;
	logic [1:0] idx_q;
	logic rd_q, wr_q, rd_smp_q;
	logic early_wr, late_wr;
	logic [NDM_WORD_AW-1:0] addr_q;
	logic ref_pend_q;
	logic [TW-1:0] ref_cnt_q;
	logic [TW-1:0] rasp_q;
	logic [NDM_BYTE_W:0] sync1_q, sync2_q;
	logic t_load, t_done;
	logic [TW-1:0] t_count;
	logic ref_tick;
	logic rasp_out;
	logic start;
	logic [NDM_BYTE_W:0] rmw_data;
	// spread refreshes evenly: one row per period slice
	assign ref_tick = (ref_cnt_q == '0);
	assign rasp_out = (rasp_q >= TW'(RASP_CYC - NDM_CAS_CYC - NDM_NP_CYC));
	assign start = (st_q == NDM_S_IDLE) && i_req && !ref_pend_q;
	assign rmw_data = i_wdata;
	assign early_wr = wr_q && !rd_q &&
		(st_d inside {NDM_S_ROW, NDM_S_CLO, NDM_S_CHI});
	// read-modify-write: write edge in the second low cycle, data sampled
	// byte lines contend with the module here; only the ninth lane is clean
	assign late_wr = wr_q && rd_q && st_q == NDM_S_CLO && !t_done;
	ndm_timer #(.W(TW)) u_tmr (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_load(t_load),
		.i_count(t_count),
		.o_done(t_done)
	);
	always_comb begin
		st_d = st_q;
		t_load = 1'b0;
		t_count = '0;
		case (st_q)
			NDM_S_PAUSE: begin
				// refresh counter is loaded with the pause at reset and times it
				if (ref_tick) begin
					st_d = NDM_S_WAKE;
					t_load = 1'b1;
					t_count = TW'(NDM_RAS_CYC);
				end
			end
			NDM_S_WAKE: begin
				if (t_done) begin
					st_d = NDM_S_PRE;
					t_load = 1'b1;
					t_count = TW'(NDM_RP_CYC);
				end
			end
			NDM_S_IDLE: begin
				if (ref_pend_q) begin
					st_d = NDM_S_CBR;
					t_load = 1'b1;
					t_count = TW'(NDM_CSR_CYC);
				end else if (i_req) begin
					st_d = NDM_S_ROW;
					t_load = 1'b1;
					t_count = TW'(NDM_RCD_CYC);
				end
			end
			NDM_S_ROW: begin
				if (t_done) begin
					st_d = NDM_S_CLO;
					t_load = 1'b1;
					t_count = TW'(NDM_CAS_CYC);
				end
			end
			NDM_S_CLO: begin
				if (t_done) begin
					t_load = 1'b1;
					// stop early rather than overrun the pulse limit
					if (left_q == 2'h0 || rasp_out) begin
						st_d = NDM_S_RUP;
						t_count = TW'(NDM_RAS_CYC);
					end else begin
						st_d = NDM_S_CHI;
						t_count = TW'(NDM_NP_CYC);
					end
				end
			end
			NDM_S_CHI: begin
				if (t_done) begin
					st_d = NDM_S_CLO;
					t_load = 1'b1;
					t_count = TW'(NDM_CAS_CYC);
				end
			end
			NDM_S_RUP: begin
				if (t_done) begin
					st_d = NDM_S_PRE;
					t_load = 1'b1;
					t_count = TW'(NDM_RP_CYC);
				end
			end
			NDM_S_PRE: begin
				if (t_done) begin
					st_d = (ras_cnt_q < 4'(NDM_INIT_RAS)) ?
						NDM_S_WAKE : NDM_S_IDLE;
					t_load = (ras_cnt_q < 4'(NDM_INIT_RAS));
					t_count = TW'(NDM_RAS_CYC);
				end
			end
			NDM_S_CBR: begin
				if (t_done) begin
					st_d = NDM_S_CBRR;
					t_load = 1'b1;
					t_count = TW'(NDM_RAS_CYC);
				end
			end
			NDM_S_CBRR: begin
				if (t_done) begin
					st_d = NDM_S_PRE;
					t_load = 1'b1;
					t_count = TW'(NDM_RP_CYC);
				end
			end
			default: st_d = NDM_S_PAUSE;
		endcase
	end
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {i_parity_dout, i_shared_byte_lines};
			sync2_q <= sync1_q;
		end
	end
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_q <= NDM_S_PAUSE;
			ras_cnt_q <= '0;
			ref_cnt_q <= TW'(INIT_CYC);
			ref_pend_q <= 1'b0;
			rasp_q <= '0;
			left_q <= '0;
			idx_q <= '0;
			rd_q <= 1'b0;
			rd_smp_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= '0;
		end else begin
			st_q <= st_d;
			if (st_q == NDM_S_WAKE && t_done)
				ras_cnt_q <= ras_cnt_q + 4'h1;
			ref_cnt_q <= ref_tick ? TW'(REF_CYC / NDM_REF_ROWS - 1) :
				ref_cnt_q - TW'(1);
			// the tick wins over the clear when both meet
			if (ref_tick && o_init_done)
				ref_pend_q <= 1'b1;
			else if (st_q == NDM_S_CBRR && t_done)
				ref_pend_q <= 1'b0;
			rasp_q <= (st_q == NDM_S_IDLE) ? '0 : rasp_q + TW'(1);
			rd_smp_q <= rd_q && st_q == NDM_S_CLO && t_done;
			if (start) begin
				left_q <= i_len_m1[1:0] | {2{i_len_m1[2]}};
				idx_q <= {i_addr[NDM_ADDR_W-1], i_addr[NDM_WORD_AW-1]};
				rd_q <= i_rd;
				wr_q <= i_wr;
				addr_q <= i_addr;
			end else if (st_q == NDM_S_CLO && t_done && st_d == NDM_S_CHI) begin
				left_q <= left_q - 2'h1;
			end else if (st_q == NDM_S_CHI && t_done) begin
				// {column, row} top bits: row counts first, wraps after four
				idx_q <= idx_q + 2'h1;
			end
		end
	end
	// output flops
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_ras_n <= 1'b1;
			o_cas_n <= 1'b1;
			o_parity_lane_column_strobe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_addr <= '0;
			o_shared_byte_lines_out <= '0;
			o_shared_byte_lines_oe <= 1'b0;
			o_parity_din <= 1'b0;
			o_ready <= 1'b0;
			o_init_done <= 1'b0;
			o_wdata_take <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_nib_idx <= '0;
		end else begin
			o_ras_n <= !(st_d == NDM_S_WAKE || st_d == NDM_S_ROW ||
				st_d == NDM_S_CLO || st_d == NDM_S_CHI ||
				st_d == NDM_S_RUP || st_d == NDM_S_CBRR);
			// both strobes move together so all nine lanes burst
			o_cas_n <= !(st_d == NDM_S_CLO || st_d == NDM_S_CBR ||
				st_d == NDM_S_CBRR);
			o_parity_lane_column_strobe_n <= !(st_d == NDM_S_CLO ||
				st_d == NDM_S_CBR || st_d == NDM_S_CBRR);
			if (start)
				o_addr <= i_addr[NDM_WORD_AW-1:NDM_ROW_POS];
			else if (st_q == NDM_S_ROW)
				o_addr <= addr_q[NDM_ADDR_W-1:0];
			o_we_n <= !(early_wr || late_wr);
			o_shared_byte_lines_oe <= early_wr || late_wr;
			if (start || (st_q == NDM_S_CHI && t_done)) begin
				o_shared_byte_lines_out <= i_wdata[NDM_BYTE_W-1:0];
				o_parity_din <= rmw_data[NDM_BYTE_W];
			end
			o_wdata_take <= start || (st_q == NDM_S_CHI && t_done);
			// one cycle after the low phase: the sync stages lag by two
			o_rvalid <= rd_smp_q;
			o_rdata <= sync2_q;
			o_nib_idx <= idx_q;
			o_init_done <= o_init_done || (ras_cnt_q >= 4'(NDM_INIT_RAS));
			// a tick landing now must drop ready, or a request is lost
			o_ready <= (st_d == NDM_S_IDLE) && !ref_pend_q &&
				!(ref_tick && o_init_done) && !start;
		end
	end
endmodule : ndm_ctrl

// >>> verification/ndm_ctrl_asserts.sv
// checker: strobe order and timing of the dram controller
`timescale 1ns/1ps
module ndm_ctrl_asserts
	import ndm_pkg::*;
#(
	parameter int unsigned REF_CYC = NDM_REF_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic o_ready,
	input wire logic o_init_done,
	input wire logic o_ras_n,
	input wire logic o_cas_n
);
	logic [31:0] gap_q;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// slack covers a refresh held back by an access in flight
	always_ff @(posedge i_mclk)
		gap_q <= (!o_init_done || ($fell(o_ras_n) && !o_cas_n)) ?
			32'h0 : gap_q + 32'h1;
	AST_INIT: assert property (!o_init_done |-> o_cas_n)
		else $error("cas before start-up");
	AST_RDY: assert property (o_ready |-> o_init_done)
		else $error("ready before start-up");
	AST_REQ: assert property (i_req && o_ready |=> !o_ras_n || !o_cas_n)
		else $error("request not started");
	AST_PRE: assert property ($rose(o_ras_n) |-> o_ras_n [*3])
		else $error("short precharge");
	AST_CSR: assert property ($fell(o_ras_n) && !o_cas_n |-> !$past(o_cas_n))
		else $error("cas setup missing");
	AST_GAP: assert property (gap_q <= REF_CYC / 512 + 40)
		else $error("refresh late");
endmodule : ndm_ctrl_asserts
bind ndm_ctrl ndm_ctrl_asserts #(.REF_CYC(REF_CYC)) i_ndm_ctrl_asserts (
	.i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req), .o_ready(o_ready),
	.o_init_done(o_init_done), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n));

// >>> verification/ndm_dram_model.sv
// model: dram module answering the controller's strobes
`timescale 1ns/1ps
module ndm_dram_model (
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_par_cas_n,
	input wire logic i_we_n,
	input wire logic [9:0] i_addr,
	input wire logic [7:0] i_dq,
	input wire logic i_din9,
	output logic [7:0] o_dq,
	output logic o_dout9
);
	logic [8:0] mem [0:1048575];
	logic [9:0] row, col;
	logic [19:0] wa;
	logic [1:0] nib;
	logic first = 0, rd = 0, cbr = 0;
	logic [8:0] q = 9'h0, drv = 9'h0;
	int ras_cnt = 0, cbr_cnt = 0;
	always @(negedge i_ras_n) begin
		#1;
		ras_cnt++;
		first = 1'b1;
		cbr = !i_cas_n;
		if (cbr) cbr_cnt++; // own row counter, pins ignored
		else row = i_addr;
	end
	always @(negedge i_cas_n) begin
		#1;
		if (!i_ras_n && !cbr) begin
			if (first) col = i_addr;
			nib = first ? {i_addr[9], row[9]} : nib + 2'h1;
			first = 1'b0;
			wa = {nib[0], row[8:0], nib[1], col[8:0]};
			rd = i_we_n; // early write keeps outputs off
			// a missing parity strobe corrupts the ninth bit
			if (!i_we_n) mem[wa] = {i_din9 ^ i_par_cas_n, i_dq};
			q = mem[wa];
		end
	end
	always @(negedge i_we_n) begin
		#1;
		if (!i_cas_n && !i_ras_n && !cbr)
			mem[wa] = {i_din9 ^ i_par_cas_n, i_dq};
	end
	// released lines flip rather than hold, so late sampling shows
	always @(i_cas_n or i_par_cas_n or i_ras_n or q or rd)
		drv = (!i_cas_n && !i_ras_n && rd) ?
			q ^ {i_par_cas_n, 8'h0} : ~drv;
	assign o_dq = drv[7:0];
	assign o_dout9 = drv[8];
endmodule : ndm_dram_model

// >>> verification/ndm_ctrl_tb.sv
// testbench: start-up, nibble bursts and refresh of the controller
`timescale 1ns/1ps
module ndm_ctrl_tb;
	logic i_mclk = 0, i_rst = 1, i_req = 0, i_rd = 0, i_wr = 0;
	logic [19:0] i_addr = 20'h0;
	logic [2:0] i_len_m1 = 3'h0;
	logic [8:0] i_wdata = 9'h0, o_rdata;
	logic o_ready, o_init_done, o_wdata_take, o_rvalid, o_ras_n, o_cas_n;
	logic we_n, oe, p_din, p_dout, p_cas_n;
	logic [1:0] o_nib_idx;
	logic [9:0] o_addr;
	logic [7:0] d_out, d_dev;
	wire [7:0] dq = oe ? d_out : d_dev;
	int error_cnt = 0, check_count = 0, cyc = 0;
	ndm_ctrl #(.INIT_CYC(20), .REF_CYC(51200)) i_ndm_ctrl (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req), .i_rd(i_rd),
		.i_wr(i_wr), .i_addr(i_addr), .i_len_m1(i_len_m1),
		.i_wdata(i_wdata), .o_ready(o_ready), .o_init_done(o_init_done),
		.o_wdata_take(o_wdata_take), .o_rvalid(o_rvalid),
		.o_rdata(o_rdata), .o_nib_idx(o_nib_idx), .o_ras_n(o_ras_n),
		.o_cas_n(o_cas_n), .o_parity_lane_column_strobe_n(p_cas_n),
		.o_we_n(we_n),
		.o_addr(o_addr), .o_shared_byte_lines_out(d_out),
		.o_shared_byte_lines_oe(oe), .i_shared_byte_lines(dq),
		.o_parity_din(p_din), .i_parity_dout(p_dout));
	ndm_dram_model i_ndm_dram_model (.i_ras_n(o_ras_n), .i_cas_n(o_cas_n),
		.i_par_cas_n(p_cas_n),
		.i_we_n(we_n), .i_addr(o_addr), .i_dq(dq), .i_din9(p_din),
		.o_dq(d_dev), .o_dout9(p_dout));
	initial forever #12.5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic burst(input logic rd, input logic wr, input logic [19:0] a,
		input logic [2:0] lm1, input logic [8:0] ek, input logic [8:0] wk);
		int n, r = 0, w = 0, t = 0;
		logic [1:0] s;
		s = {a[9], a[19]};
		n = (lm1 > 3) ? 4 : lm1 + 1;
		i_rd <= rd;
		i_wr <= wr;
		i_addr <= a;
		i_len_m1 <= lm1;
		i_wdata <= wk + {7'h0, s};
		i_req <= 1'b1;
		do @(posedge i_mclk); while (o_ready !== 1'b1);
		i_req <= 1'b0;
		while (t < 80 && (t < 2 || o_ready !== 1'b1)) begin
			@(posedge i_mclk);
			t++;
			if (o_wdata_take === 1'b1) begin
				w++;
				i_wdata <= wk + {7'h0, s + w[1:0]};
			end
			if (o_rvalid === 1'b1) begin
				chk_val(o_rdata, ek + {7'h0, s + r[1:0]});
				chk_val({7'h0, o_nib_idx}, {7'h0, s + r[1:0]});
				r++;
			end
		end
		chk_val({8'h0, rd ? r == n : w == n}, 9'h1);
	endtask : burst
	task automatic sc_init;
		i_rst <= 1'b0;
		// no row strobe may come while the pause runs
		repeat (20) @(posedge i_mclk);
		chk_val({8'h0, i_ndm_dram_model.ras_cnt == 0}, 9'h1);
		while (o_init_done !== 1'b1) @(posedge i_mclk);
		chk_val({8'h0, i_ndm_dram_model.ras_cnt == 8}, 9'h1);
	endtask : sc_init
	// rows share column bits, so a swapped half shows on read back
	task automatic sc_burst;
		burst(1'b0, 1'b1, 20'h80155, 3'h7, 9'h0, 9'h0a5);
		burst(1'b0, 1'b1, 20'h81155, 3'h7, 9'h0, 9'h13c);
		burst(1'b1, 1'b0, 20'h80155, 3'h7, 9'h0a5, 9'h0);
		burst(1'b1, 1'b0, 20'h81155, 3'h1, 9'h13c, 9'h0);
		burst(1'b1, 1'b1, 20'h80155, 3'h3, 9'h0a5, 9'h1c3);
		burst(1'b1, 1'b0, 20'h80355, 3'h3, 9'h1c3, 9'h0);
	endtask : sc_burst
	task automatic sc_refresh;
		int c0;
		c0 = i_ndm_dram_model.cbr_cnt;
		repeat (400) @(posedge i_mclk);
		chk_val({8'h0, i_ndm_dram_model.cbr_cnt - c0 >= 3 &&
			i_ndm_dram_model.cbr_cnt - c0 <= 5}, 9'h1);
	endtask : sc_refresh
	task automatic complete_run;
		if (error_cnt == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	initial begin
		repeat (5) @(posedge i_mclk);
		sc_init();
		sc_burst();
		sc_refresh();
		complete_run();
	end
endmodule : ndm_ctrl_tb
